// File: dv/rcl_flash_model.sv
// rcl_flash_model: flash array partner that holds the option byte
// assumes: read request is a one-cycle pulse, address held steady until the answer
`timescale 1ns/1ps
`default_nettype none
module rcl_flash_model (
    input  wire logic        i_clk,
    input  wire logic        i_rd,
    input  wire logic [23:0] i_addr,
    input  wire logic [7:0]  i_opt_byte,
    input  wire logic        i_fault,
    input  wire logic [3:0]  i_lat,
    output var  logic        o_rvalid,
    output var  logic [7:0]  o_rdata,
    output var  logic        o_dbl_fault
);
    logic [3:0] cnt_q;
    logic       pend_q;
    initial begin
        o_rvalid = 1'b0;
        o_rdata = 8'h00;
        o_dbl_fault = 1'b0;
        cnt_q = 4'h0;
        pend_q = 1'b0;
    end
    // ------------------------------------------------------------
    // read answer after i_lat cycles; data lines toggle when idle
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        o_rvalid    <= 1'b0;
        o_rdata     <= ~o_rdata;
        o_dbl_fault <= ~o_dbl_fault;
        if (i_rd) begin
            pend_q <= 1'b1;
            cnt_q  <= i_lat;
        end else if (pend_q && cnt_q > 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (pend_q) begin
            pend_q      <= 1'b0;
            o_rvalid    <= 1'b1;
            o_rdata     <= (i_addr == rcl_pkg::FLASH_OPT_ADDR) ?
                           i_opt_byte : 8'hA5;
            o_dbl_fault <= i_fault;
        end
    end
endmodule // rcl_flash_model
`default_nettype wire

// File: dv/rcl_top_tb.sv
// rcl_top_tb: reset sequences, option byte decode and register port
// assumes: rcl_pkg, rcl_top and rcl_flash_model compiled before
`timescale 1ns/1ps
`default_nettype none
module rcl_top_tb;
    localparam int SAW = 3;
    logic             i_clk, i_rstn, i_por_req, i_warm_req, i_lvr_req;
    logic             busy, rvalid, dfault, i_wr, i_rd, fault;
    logic [7:0]       rdata, i_addr, i_wdata, o_rdata, opt, rd_d;
    logic             o_cpu_stall, o_flash_abort, o_flash_rd, win;
    logic [23:0]      o_flash_addr;
    logic [2:0]       rate, er;
    logic             o_watchdog_run, o_prot_active, o_periph_rst;
    logic             o_rtc_rst, o_sram_we, stall_rv, ce;
    logic [SAW-1:0]   o_sram_addr;
    logic [31:0]      o_sram_wdata;
    logic [6:0]       o_sram_ecc;
    logic [3:0]       lat;
    logic [7:0]       sram_cnt, abort_cnt, rtc_cnt, prst_cnt, bad_run;
    int               err_total, samples_checked;

    rcl_top #(.SRAM_AW(SAW)) i_dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce),
        .i_por_req(i_por_req), .i_warm_req(i_warm_req),
        .i_lvr_req(i_lvr_req), .i_flash_busy(busy),
        .i_flash_rvalid(rvalid), .i_flash_rdata(rdata),
        .i_flash_dbl_fault(dfault), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_cpu_stall(o_cpu_stall), .o_flash_abort(o_flash_abort),
        .o_flash_rd(o_flash_rd), .o_flash_addr(o_flash_addr),
        .o_watchdog_rate_select(rate), .o_watchdog_window_mode(win),
        .o_watchdog_run(o_watchdog_run), .o_prot_active(o_prot_active),
        .o_periph_rst(o_periph_rst), .o_rtc_rst(o_rtc_rst),
        .o_sram_we(o_sram_we), .o_sram_addr(o_sram_addr),
        .o_sram_wdata(o_sram_wdata), .o_sram_ecc(o_sram_ecc));

    rcl_flash_model i_flash (
        .i_clk(i_clk), .i_rd(o_flash_rd), .i_addr(o_flash_addr),
        .i_opt_byte(opt), .i_fault(fault), .i_lat(lat),
        .o_rvalid(rvalid), .o_rdata(rdata), .o_dbl_fault(dfault));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // ------------------------------------------------------------
    // monitors
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (o_sram_we === 1'b1 && (o_sram_wdata | o_sram_ecc) !== 0)
            bad_run++;
        if (o_sram_we === 1'b1 && o_sram_addr !== sram_cnt[SAW-1:0])
            bad_run++;
        if (o_sram_we === 1'b1) sram_cnt++;
        if (o_flash_abort === 1'b1) abort_cnt++;
        if (o_rtc_rst === 1'b1) rtc_cnt++;
        if (o_periph_rst === 1'b1) prst_cnt++;
        if (o_watchdog_run === 1'b1 && o_cpu_stall !== 1'b0) bad_run++;
        if (rvalid === 1'b1) stall_rv = o_cpu_stall;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic req(input int kind);
        @(negedge i_clk);
        sram_cnt = 8'h00;
        abort_cnt = 8'h00;
        rtc_cnt = 8'h00;
        prst_cnt = 8'h00;
        stall_rv = 1'b0;
        @(posedge i_clk);
        i_por_req  <= (kind == 0);
        i_warm_req <= (kind == 1);
        i_lvr_req  <= (kind == 2);
        @(posedge i_clk);
        i_por_req  <= 1'b0;
        i_warm_req <= 1'b0;
        i_lvr_req  <= 1'b0;
    endtask
    task automatic settle;
        int n;
        n = 0;
        repeat (2) @(posedge i_clk);
        #1;
        while (o_cpu_stall !== 1'b0 && n < 300) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk(24'(n < 300), 24'h1);
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    task automatic end_test(input string name);
        $display("test %s done, checks=%0d", name, samples_checked);
    endtask
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #(40 * 30000);
        err_total++;
        wrap_up;
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {i_rstn, i_por_req, i_warm_req, i_lvr_req, busy, i_wr, i_rd} = 0;
        {fault, stall_rv} = 0;
        ce = 1'b1;
        {i_addr, i_wdata} = 16'h0000;
        {sram_cnt, abort_cnt, rtc_cnt, prst_cnt, bad_run} = 40'h0;
        {err_total, samples_checked} = 0;
        opt = 8'h52;
        lat = 4'h3;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        settle;
        chk(sram_cnt, 8'(1 << SAW));
        chk(o_flash_addr, rcl_pkg::FLASH_OPT_ADDR);
        reg_rd(rcl_pkg::REG_STATUS, rd_d);
        chk(rd_d, 8'hDA);
        end_test("power_up");
        for (int c = 0; c < 16; c++) begin
            opt = 8'h50 | 8'(c);
            lat = 4'(1 + c % 4);
            er = ~opt[2:0];
            req(1);
            settle;
            chk(rate, er);
            chk(win, {~opt[3]});
            chk(stall_rv, 1'b1);
            chk(sram_cnt, 8'h00);
            chk(rtc_cnt, 8'h00);
            chk(prst_cnt, 8'h01);
            chk(o_flash_addr, rcl_pkg::FLASH_OPT_ADDR);
        end
        end_test("warm_decode");
        fault = 1'b1;
        req(1);
        settle;
        chk(o_prot_active, 1'b1);
        fault = 1'b0;
        req(1);
        settle;
        chk(o_prot_active, 1'b0);
        end_test("double_fault");
        busy = 1'b1;
        req(1);
        settle;
        chk(abort_cnt, 8'h01);
        busy = 1'b0;
        req(1);
        settle;
        chk(abort_cnt, 8'h00);
        end_test("abort");
        req(2);
        settle;
        chk(sram_cnt, 8'(1 << SAW));
        chk(rtc_cnt, 8'h00);
        req(0);
        settle;
        chk(sram_cnt, 8'(1 << SAW));
        chk(rtc_cnt, 8'h01);
        end_test("por_lvr");
        lat = 4'h8;
        opt = 8'h0D;
        req(1);
        reg_wr(rcl_pkg::REG_CTRL, 8'h01);
        reg_rd(rcl_pkg::REG_CTRL, rd_d);
        chk(rd_d, 8'h01);
        chk(o_watchdog_run, 1'b0);
        settle;
        chk(o_watchdog_run, 1'b1);
        reg_wr(rcl_pkg::REG_STATUS, 8'hFF);
        reg_rd(rcl_pkg::REG_STATUS, rd_d);
        chk(rd_d, 8'h22);
        reg_rd(8'h05, rd_d);
        chk(rd_d, 8'h00);
        req(1);
        settle;
        chk(o_watchdog_run, 1'b0);
        reg_rd(rcl_pkg::REG_CTRL, rd_d);
        chk(rd_d, 8'h00);
        chk(bad_run, 8'h00);
        ce <= 1'b0;
        req(1);
        repeat (3) @(posedge i_clk);
        #1;
        chk(o_cpu_stall, 1'b0);
        chk(prst_cnt, 8'h00);
        ce <= 1'b1;
        end_test("registers");
        wrap_up;
    end
endmodule // rcl_top_tb
`default_nettype wire

// File: logic/rcl_pkg.sv
// rcl_pkg: constants of the reset configuration loader
// assumes: included before every rcl design file
package rcl_pkg;
    // flash configuration byte
    localparam logic [23:0] FLASH_OPT_ADDR    = 24'hFFFE0E;
    localparam int          RATE_LSB          = 0;
    localparam int          RATE_MSB          = 2;
    localparam int          WIN_BIT           = 3;
    // register index map
    localparam logic [7:0]  REG_STATUS        = 8'h00;
    localparam logic [7:0]  REG_CTRL          = 8'h01;
    // control register fields
    localparam int          CTRL_WDOG_EN      = 0;
    localparam logic [7:0]  CTRL_RST          = 8'h00;
    // status register fields
    localparam int          ST_STALL          = 0;
    localparam int          ST_LOADED         = 1;
    localparam int          ST_PROT           = 2;
    localparam int          ST_WINDOW         = 3;
    localparam int          ST_RATE_LSB       = 4;
    localparam int          ST_POR            = 7;
    // reset values of loaded watchdog fields
    localparam logic [2:0]  RATE_RST          = 3'h0;
    localparam logic        WINDOW_RST        = 1'b0;
    // system ram geometry defaults
    localparam int          SRAM_AW_DEF       = 10;
    localparam int          SRAM_DW_DEF       = 32;
    localparam int          SRAM_EW_DEF       = 7;
    // sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_RUN   = 5'h01,
        ST_ABORT = 5'h02,
        ST_FETCH = 5'h04,
        ST_WAIT  = 5'h08,
        ST_RINIT = 5'h10
    } rcl_state_e;
endpackage

// File: logic/rcl_ram_init.sv
// rcl_ram_init: walks the system ram writing zero data and zero syndrome
// assumes: one clock, synchronous active-low reset, clock enable
`timescale 1ns/1ps
`default_nettype none
module rcl_ram_init #(
    parameter int AW = rcl_pkg::SRAM_AW_DEF,
    parameter int DW = rcl_pkg::SRAM_DW_DEF,
    parameter int EW = rcl_pkg::SRAM_EW_DEF
) (
    input  wire logic          i_clk,
    input  wire logic          i_rstn,
    input  wire logic          i_ce,
    input  wire logic          i_start,
    input  wire logic          i_stop,
    output var  logic          o_busy,
    output var  logic          o_we,
    output var  logic [AW-1:0] o_addr,
    output var  logic [DW-1:0] o_wdata,
    output var  logic [EW-1:0] o_ecc
);
    localparam logic [AW-1:0] LAST = {AW{1'b1}};

    if (AW < 2 || AW > 24) begin : g_bad_aw
        $error("rcl_ram_init: AW out of range");
    end

    // ------------------------------------------------------------
    // address walk
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_busy <= 1'b0;
            o_we   <= 1'b0;
            o_addr <= '0;
        end else if (i_ce) begin
            if (i_stop) begin
                o_busy <= 1'b0;
                o_we   <= 1'b0;
            end else if (i_start) begin
                o_busy <= 1'b1;
                o_we   <= 1'b1;
                o_addr <= '0;
            end else if (o_busy) begin
                if (o_addr == LAST) begin
                    o_busy <= 1'b0;
                    o_we   <= 1'b0;
                end else begin
                    o_addr <= o_addr + 1'b1;
                end
            end
        end
    end

    // data and syndrome of an all-zero word
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_wdata <= '0;
            o_ecc   <= '0;
        end
    end
endmodule // rcl_ram_init
`default_nettype wire

// File: logic/rcl_top.sv
// rcl_top: reset-time configuration loader and cpu hold
// assumes: flash answers one read with i_flash_rvalid, any latency;
// reset requests are one-cycle pulses synchronous to i_clk
//
// What this block does
// - on every reset hold the cpu until flash configuration is loaded.
// - double fault during load leaves protection and security active.
// - reset during a flash program or erase aborts it at once.
// - power-on reset initialises system ram and syndromes; warm reset does not.
// - no other ram array is initialised by any reset.
// - ram content survives warm resets only; power-on and low-voltage ones clear it.
// - load watchdog rate and window bit from option byte at fixed address.
// - loaded watchdog rate is the bitwise inverse of the stored code.
// - loaded window mode is the inverse of stored bit three.
// - any reset reinitialises registers; rtc registers only on power-on.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rcl_top #(
    parameter int SRAM_AW = rcl_pkg::SRAM_AW_DEF,
    parameter int SRAM_DW = rcl_pkg::SRAM_DW_DEF,
    parameter int SRAM_EW = rcl_pkg::SRAM_EW_DEF
) (
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    input  wire logic               i_ce,
    input  wire logic               i_por_req,
    input  wire logic               i_warm_req,
    input  wire logic               i_lvr_req,
    input  wire logic               i_flash_busy,
    input  wire logic               i_flash_rvalid,
    input  wire logic [7:0]         i_flash_rdata,
    input  wire logic               i_flash_dbl_fault,
    input  wire logic [7:0]         i_addr,
    input  wire logic [7:0]         i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output var  logic [7:0]         o_rdata,
    output var  logic               o_cpu_stall,
    output var  logic               o_flash_abort,
    output var  logic               o_flash_rd,
    output var  logic [23:0]        o_flash_addr,
    output var  logic [2:0]         o_watchdog_rate_select,
    output var  logic               o_watchdog_window_mode,
    output var  logic               o_watchdog_run,
    output var  logic               o_prot_active,
    output var  logic               o_periph_rst,
    output var  logic               o_rtc_rst,
    output var  logic               o_sram_we,
    output var  logic [SRAM_AW-1:0] o_sram_addr,
    output var  logic [SRAM_DW-1:0] o_sram_wdata,
    output var  logic [SRAM_EW-1:0] o_sram_ecc
);
    if (SRAM_DW < 8 || SRAM_EW < 1) begin : g_bad_width
        $error("rcl_top: ram width out of range");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    rcl_pkg::rcl_state_e state_q;
    rcl_pkg::rcl_state_e state_d;
    logic       any_req;
    logic       kind_por_q;
    logic       kind_lvr_q;
    logic       loaded_q;
    logic       ram_busy;
    logic       ram_start_q;
    logic [7:0] ctrl_q;
    logic [7:0] status;

    assign any_req = i_por_req | i_warm_req | i_lvr_req;

    // ------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            rcl_pkg::ST_RUN:   state_d = rcl_pkg::ST_RUN;
            rcl_pkg::ST_ABORT: state_d = rcl_pkg::ST_FETCH;
            rcl_pkg::ST_FETCH: state_d = rcl_pkg::ST_WAIT;
            rcl_pkg::ST_WAIT: begin
                if (i_flash_rvalid) begin
                    if (kind_por_q || kind_lvr_q) begin
                        state_d = rcl_pkg::ST_RINIT;
                    end else begin
                        state_d = rcl_pkg::ST_RUN;
                    end
                end
            end
            rcl_pkg::ST_RINIT: begin
                if (!ram_start_q && !ram_busy) begin
                    state_d = rcl_pkg::ST_RUN;
                end
            end
            default: state_d = rcl_pkg::ST_ABORT;
        endcase
        if (any_req) begin
            state_d = rcl_pkg::ST_ABORT;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_q <= rcl_pkg::ST_ABORT;
        end else if (i_ce) begin
            state_q <= state_d;
        end
    end

    // kind of the reset being served; power-on wins over the others
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            kind_por_q <= 1'b1;
            kind_lvr_q <= 1'b0;
        end else if (i_ce && any_req) begin
            kind_por_q <= i_por_req;
            kind_lvr_q <= i_lvr_req & ~i_por_req;
        end
    end

    // cpu hold until the sequence is back in run
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_cpu_stall <= 1'b1;
        end else if (i_ce) begin
            o_cpu_stall <= (state_d != rcl_pkg::ST_RUN);
        end
    end

    // ------------------------------------------------------------
    // flash side
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_flash_abort <= 1'b0;
        end else if (i_ce) begin
            o_flash_abort <= (state_q == rcl_pkg::ST_ABORT) &
                             i_flash_busy;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_flash_rd   <= 1'b0;
            o_flash_addr <= '0;
        end else if (i_ce) begin
            o_flash_rd <= (state_q == rcl_pkg::ST_FETCH) & ~any_req;
            if (state_q == rcl_pkg::ST_FETCH) begin
                o_flash_addr <= rcl_pkg::FLASH_OPT_ADDR;
            end
        end
    end

    // option byte capture, stored inverted
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_watchdog_rate_select <= rcl_pkg::RATE_RST;
            o_watchdog_window_mode <= rcl_pkg::WINDOW_RST;
            loaded_q               <= 1'b0;
        end else if (i_ce) begin
            if (any_req) begin
                o_watchdog_rate_select <= rcl_pkg::RATE_RST;
                o_watchdog_window_mode <= rcl_pkg::WINDOW_RST;
                loaded_q               <= 1'b0;
            end else if (state_q == rcl_pkg::ST_WAIT && i_flash_rvalid) begin
                o_watchdog_rate_select <= ~i_flash_rdata[rcl_pkg::RATE_MSB:
                                          rcl_pkg::RATE_LSB];
                o_watchdog_window_mode <=
                    ~i_flash_rdata[rcl_pkg::WIN_BIT];
                loaded_q               <= 1'b1;
            end
        end
    end

    // protection stays active out of reset when the load was faulty
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_prot_active <= 1'b0;
        end else if (i_ce) begin
            if (any_req) begin
                o_prot_active <= 1'b0;
            end else if (state_q == rcl_pkg::ST_WAIT && i_flash_rvalid) begin
                o_prot_active <= i_flash_dbl_fault;
            end
        end
    end

    // ------------------------------------------------------------
    // peripheral and rtc reset pulses
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_periph_rst <= 1'b1;
            o_rtc_rst    <= 1'b1;
        end else if (i_ce) begin
            o_periph_rst <= any_req;
            o_rtc_rst    <= i_por_req;
        end
    end

    // ------------------------------------------------------------
    // system ram initialisation; only this array is ever written
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ram_start_q <= 1'b0;
        end else if (i_ce) begin
            ram_start_q <= (state_q == rcl_pkg::ST_WAIT) & i_flash_rvalid &
                           (kind_por_q | kind_lvr_q) & ~any_req;
        end
    end

    rcl_ram_init #(
        .AW (SRAM_AW),
        .DW (SRAM_DW),
        .EW (SRAM_EW)
    ) u_ram_init (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_ce    (i_ce),
        .i_start (ram_start_q),
        .i_stop  (any_req),
        .o_busy  (ram_busy),
        .o_we    (o_sram_we),
        .o_addr  (o_sram_addr),
        .o_wdata (o_sram_wdata),
        .o_ecc   (o_sram_ecc)
    );

    // ------------------------------------------------------------
    // watchdog start gate
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_watchdog_run <= 1'b0;
        end else if (i_ce) begin
            o_watchdog_run <= ctrl_q[rcl_pkg::CTRL_WDOG_EN] & loaded_q &
                              ~o_cpu_stall & ~any_req &
                              (state_q == rcl_pkg::ST_RUN);
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ctrl_q <= rcl_pkg::CTRL_RST;
        end else if (i_ce) begin
            if (any_req) begin
                ctrl_q <= rcl_pkg::CTRL_RST;
            end else if (i_wr && i_addr == rcl_pkg::REG_CTRL) begin
                ctrl_q <= i_wdata;
            end
        end
    end

    always_comb begin
        status = '0;
        status[rcl_pkg::ST_STALL]  = o_cpu_stall;
        status[rcl_pkg::ST_LOADED] = loaded_q;
        status[rcl_pkg::ST_PROT]   = o_prot_active;
        status[rcl_pkg::ST_WINDOW] = o_watchdog_window_mode;
        status[rcl_pkg::ST_RATE_LSB+:3] = o_watchdog_rate_select;
        status[rcl_pkg::ST_POR]    = kind_por_q;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_rdata <= '0;
        end else if (i_ce) begin
            o_rdata <= '0;
            if (i_rd && i_addr == rcl_pkg::REG_STATUS) begin
                o_rdata <= status;
            end else if (i_rd && i_addr == rcl_pkg::REG_CTRL) begin
                o_rdata <= ctrl_q;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_stall_hold;
        @(posedge i_clk) disable iff (!i_rstn || !i_ce)
        !loaded_q |-> o_cpu_stall;
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("cpu released before configuration loaded");

    property p_prot_fault;
        @(posedge i_clk) disable iff (!i_rstn || !i_ce)
        (state_q == rcl_pkg::ST_WAIT && i_flash_rvalid && !any_req)
        |=> o_prot_active == $past(i_flash_dbl_fault);
    endproperty
    a_prot_fault: assert property (p_prot_fault)
        else $error("protection does not follow double fault");

    property p_abort;
        @(posedge i_clk) disable iff (!i_rstn || !i_ce)
        (any_req && i_flash_busy) ##1 i_flash_busy |=> o_flash_abort;
    endproperty
    a_abort: assert property (p_abort)
        else $error("busy flash command not aborted");

    property p_warm_no_init;
        @(posedge i_clk) disable iff (!i_rstn || !i_ce)
        (state_q == rcl_pkg::ST_WAIT && i_flash_rvalid && !any_req &&
         !kind_por_q && !kind_lvr_q) |=> !o_sram_we [*3];
    endproperty
    a_warm_no_init: assert property (p_warm_no_init)
        else $error("ram written after warm reset");

    property p_por_init;
        @(posedge i_clk) disable iff (!i_rstn || !i_ce)
        (state_q == rcl_pkg::ST_WAIT && i_flash_rvalid && !any_req &&
         kind_por_q) |=> ##1 (o_sram_we && o_sram_addr == '0);
    endproperty
    a_por_init: assert property (p_por_init)
        else $error("ram not initialised after power-on");

    property p_fetch_addr;
        @(posedge i_clk) disable iff (!i_rstn || !i_ce)
        (state_q == rcl_pkg::ST_FETCH && !any_req)
        |=> (o_flash_rd && o_flash_addr == rcl_pkg::FLASH_OPT_ADDR);
    endproperty
    a_fetch_addr: assert property (p_fetch_addr)
        else $error("option byte fetched from wrong address");

    property p_rate_inv;
        @(posedge i_clk) disable iff (!i_rstn || !i_ce)
        (state_q == rcl_pkg::ST_WAIT && i_flash_rvalid && !any_req)
        |=> o_watchdog_rate_select == ~$past(i_flash_rdata[2:0]);
    endproperty
    a_rate_inv: assert property (p_rate_inv)
        else $error("watchdog rate not inverse of stored code");

    property p_win_inv;
        @(posedge i_clk) disable iff (!i_rstn || !i_ce)
        (state_q == rcl_pkg::ST_WAIT && i_flash_rvalid && !any_req)
        |=> o_watchdog_window_mode != $past(i_flash_rdata[3]);
    endproperty
    a_win_inv: assert property (p_win_inv)
        else $error("window mode not inverse of stored bit");

    property p_rtc_por_only;
        @(posedge i_clk) disable iff (!i_rstn || !i_ce)
        (any_req && !i_por_req) |=> (o_periph_rst && !o_rtc_rst);
    endproperty
    a_rtc_por_only: assert property (p_rtc_por_only)
        else $error("rtc reset on non power-on reset");

    property p_wdog_gate;
        @(posedge i_clk) disable iff (!i_rstn || !i_ce)
        o_watchdog_run |-> (loaded_q && !o_cpu_stall);
    endproperty
    a_wdog_gate: assert property (p_wdog_gate)
        else $error("watchdog running before load and release");
endmodule // rcl_top
`default_nettype wire
